// file: hw/led_pulse_and_pwm_generator.sv
`timescale 1ns/100ps
module led_pulse_and_pwm_generator import led_pwm_pkg::*; #(
  parameter int TICK_CYCLES = IND_TICK_CYCLES,
  parameter int PWM_CYCLES = PWM_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // gpio configuration from the gpio block
  input wire logic gpio_is_output_i,
  input wire logic gpio_sel_pwm_i,
  input wire logic gpio_set_i,
  // outputs
  output logic [1:0] ind_o,
  output logic pwm_o,
  output logic gpio_o,
  output logic gpio_oe_o
);
  // elaboration checks
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << 20)) begin : g_chk_tick
    $error("TICK_CYCLES out of range");
  end
  if (PWM_CYCLES < 1 || PWM_CYCLES >= (1 << 21)) begin : g_chk_pwm
    $error("PWM_CYCLES out of range");
  end

  // period in ticks: code n gives 2^n ticks of 62.5 ms
  function automatic logic [7:0] period_ticks(input logic [2:0] code);
    period_ticks = 8'h01 << code;
  endfunction
  // on time in ticks: code n gives 2^n ticks
  function automatic logic [7:0] width_ticks(input logic [1:0] code);
    width_ticks = 8'h01 << code;
  endfunction

  // software registers
  logic [7:0] period_q, period_d;
  logic [7:0] pulse_q, pulse_d;
  logic [7:0] freq_q, freq_d;
  logic [7:0] duty_q, duty_d;
  logic [7:0] rdata_q, rdata_d;

  // register write and read decode
  always_comb begin
    period_d = period_q;
    pulse_d = pulse_q;
    freq_d = freq_q;
    duty_d = duty_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_PERIOD: period_d = reg_wdata_i & MASK_PERIOD;
        OFS_PULSE: pulse_d = reg_wdata_i & MASK_PULSE;
        OFS_FREQ: freq_d = reg_wdata_i & MASK_FREQ;
        OFS_DUTY: duty_d = reg_wdata_i;
        default: ;
      endcase
    end
    case (reg_addr_i)
      OFS_PERIOD: rdata_d = period_q;
      OFS_PULSE: rdata_d = pulse_q;
      OFS_FREQ: rdata_d = freq_q;
      OFS_DUTY: rdata_d = duty_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_q <= RST_PERIOD;
      pulse_q <= RST_PULSE;
      freq_q <= RST_FREQ;
      duty_q <= RST_DUTY;
      rdata_q <= 8'h00;
    end else begin
      period_q <= period_d;
      pulse_q <= pulse_d;
      freq_q <= freq_d;
      duty_q <= duty_d;
      rdata_q <= rdata_d;
    end
  end

  // 62.5 ms tick divider
  logic [19:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  always_comb begin
    tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 20'h00000 : tick_cnt_q + 20'h00001;
  end

  // per channel active settings and phase
  logic [2:0] act_per_q[2], act_per_d[2];
  logic [1:0] act_wid_q[2], act_wid_d[2];
  logic act_dbl_q[2], act_dbl_d[2];
  logic [7:0] phase_q[2], phase_d[2];
  logic [1:0] ind_q, ind_d;
  logic [2:0] sw_per[2];
  logic [1:0] sw_wid[2];
  logic sw_dbl[2];
  logic [7:0] wid[2];
  // on time of the settings held next cycle
  logic [7:0] wid_n[2];
  logic last_tick[2];

  // indicator sequencers
  always_comb begin
    sw_per[0] = period_q[POS_A_PERIOD +: 3];
    sw_per[1] = period_q[POS_B_PERIOD +: 3];
    sw_wid[0] = pulse_q[POS_A_WIDTH +: 2];
    sw_wid[1] = pulse_q[POS_B_WIDTH +: 2];
    sw_dbl[0] = pulse_q[POS_A_DOUBLE];
    sw_dbl[1] = pulse_q[POS_B_DOUBLE];
    for (int c = 0; c < 2; c++) begin
      act_per_d[c] = act_per_q[c];
      act_wid_d[c] = act_wid_q[c];
      act_dbl_d[c] = act_dbl_q[c];
      phase_d[c] = phase_q[c];
      wid[c] = width_ticks(act_wid_q[c]);
      // last tick of the period, or idle channel
      last_tick[c] = (phase_q[c] == period_ticks(act_per_q[c]) - 8'h01)
                     || (act_per_q[c] == 3'h0);
      if (tick) begin
        if (last_tick[c]) begin
          // reload settings at the boundary
          act_per_d[c] = sw_per[c];
          act_wid_d[c] = sw_wid[c];
          act_dbl_d[c] = sw_dbl[c];
          phase_d[c] = 8'h00;
        end else begin
          phase_d[c] = phase_q[c] + 8'h01;
        end
      end
      // output follows next cycle's settings and phase, so pulses last whole ticks
      wid_n[c] = width_ticks(act_wid_d[c]);
      // first pulse, then second pulse when double
      ind_d[c] = (act_per_d[c] != 3'h0) && ((phase_d[c] < wid_n[c])
                 || (act_dbl_d[c] && phase_d[c] >= (wid_n[c] << 1)
                     && phase_d[c] < 8'((wid_n[c] << 1) + wid_n[c])));
    end
  end

  // indicator storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 20'h00000;
      ind_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        act_per_q[c] <= 3'h0;
        act_wid_q[c] <= 2'h0;
        act_dbl_q[c] <= 1'b0;
        phase_q[c] <= 8'h00;
      end
    end else begin
      tick_cnt_q <= tick_cnt_d;
      ind_q <= ind_d;
      for (int c = 0; c < 2; c++) begin
        act_per_q[c] <= act_per_d[c];
        act_wid_q[c] <= act_wid_d[c];
        act_dbl_q[c] <= act_dbl_d[c];
        phase_q[c] <= phase_d[c];
      end
    end
  end

  // pwm state
  logic [23:0] pwm_cnt_q, pwm_cnt_d;
  logic [1:0] pwm_rate_q, pwm_rate_d;
  logic [7:0] pwm_duty_q, pwm_duty_d;
  logic pwm_q, pwm_d, gpio_q, gpio_d, gpio_oe_q, gpio_oe_d;
  logic [23:0] pwm_len;
  logic [31:0] pwm_prod;
  logic pwm_end;

  // pwm counter and compare
  always_comb begin
    pwm_len = 24'(PWM_CYCLES) << pwm_rate_q;
    pwm_end = (pwm_cnt_q == pwm_len - 24'h000001);
    pwm_cnt_d = pwm_end ? 24'h000000 : pwm_cnt_q + 24'h000001;
    pwm_rate_d = pwm_end ? freq_q[POS_RATE +: 2] : pwm_rate_q;
    pwm_duty_d = pwm_end ? duty_q : pwm_duty_q;
    pwm_prod = 32'(pwm_duty_q) * 32'(pwm_len);
    pwm_d = pwm_cnt_q < pwm_prod[31:DUTY_STEPS_LOG2];
    gpio_oe_d = gpio_is_output_i;
    gpio_d = gpio_is_output_i && (gpio_sel_pwm_i ? pwm_d : gpio_set_i);
  end

  // pwm storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_cnt_q <= 24'h000000;
      pwm_rate_q <= 2'h0;
      pwm_duty_q <= 8'h00;
      pwm_q <= 1'b0;
      gpio_q <= 1'b0;
      gpio_oe_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      pwm_rate_q <= pwm_rate_d;
      pwm_duty_q <= pwm_duty_d;
      pwm_q <= pwm_d;
      gpio_q <= gpio_d;
      gpio_oe_q <= gpio_oe_d;
    end
  end

  // outputs
  assign reg_rdata_o = rdata_q;
  assign ind_o = ind_q;
  assign pwm_o = pwm_q;
  assign gpio_o = gpio_q;
  assign gpio_oe_o = gpio_oe_q;

  // checks
  property p_a_off;
    @(posedge clk_i) disable iff (rst_i)
    (act_per_q[0] == 3'h0) |-> !ind_o[0];
  endproperty
  a_a_off: assert property (p_a_off) else $error("channel a on while off");
  property p_b_off;
    @(posedge clk_i) disable iff (rst_i)
    (act_per_q[1] == 3'h0) |-> !ind_o[1];
  endproperty
  a_b_off: assert property (p_b_off) else $error("channel b on while off");
  property p_phase_range;
    @(posedge clk_i) disable iff (rst_i)
    (act_per_q[0] != 3'h0) |-> phase_q[0] < period_ticks(act_per_q[0]);
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("phase past period");
  property p_a_start_on;
    @(posedge clk_i) disable iff (rst_i)
    (phase_q[0] == 8'h00 && act_per_q[0] != 3'h0) |-> ind_o[0];
  endproperty
  a_a_start_on: assert property (p_a_start_on) else $error("no pulse at start");
  property p_b_gap;
    @(posedge clk_i) disable iff (rst_i)
    (act_per_q[1] != 3'h0 && phase_q[1] >= wid[1] && phase_q[1] < (wid[1] << 1))
      |-> !ind_o[1];
  endproperty
  a_b_gap: assert property (p_b_gap) else $error("gap not off");
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !tick |=> $stable(act_per_q[0]) && $stable(act_wid_q[1]) && $stable(act_dbl_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed mid period");
  property p_pwm_zero;
    @(posedge clk_i) disable iff (rst_i)
    (pwm_duty_q == 8'h00) |=> !pwm_o;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("pwm high at zero duty");
  property p_pwm_start;
    @(posedge clk_i) disable iff (rst_i)
    (pwm_cnt_q == 24'h000000 && 32'(pwm_duty_q) * 32'(pwm_len) >= 32'h00000100) |=> pwm_o;
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("pwm low at period start");
  property p_route;
    @(posedge clk_i) disable iff (rst_i)
    (gpio_is_output_i && !gpio_sel_pwm_i) |=> gpio_o == $past(gpio_set_i);
  endproperty
  a_route: assert property (p_route) else $error("gpio not software value");
  property p_route_pwm;
    @(posedge clk_i) disable iff (rst_i)
    (gpio_is_output_i && gpio_sel_pwm_i) |=> gpio_o == pwm_o;
  endproperty
  a_route_pwm: assert property (p_route_pwm) else $error("gpio not pwm");
endmodule

// file: hw/led_pwm_pkg.sv
package led_pwm_pkg;
  // register offsets
  localparam logic [7:0] OFS_PERIOD = 8'h6C;
  localparam logic [7:0] OFS_PULSE = 8'h6D;
  localparam logic [7:0] OFS_FREQ = 8'h6E;
  localparam logic [7:0] OFS_DUTY = 8'h6F;
  // reset values
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_FREQ = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  // field positions
  localparam int POS_A_PERIOD = 0;
  localparam int POS_B_PERIOD = 3;
  localparam int POS_A_WIDTH = 0;
  localparam int POS_B_WIDTH = 2;
  localparam int POS_A_DOUBLE = 4;
  localparam int POS_B_DOUBLE = 5;
  localparam int POS_RATE = 0;
  // writable bit masks, other bits read zero
  localparam logic [7:0] MASK_PERIOD = 8'h3F;
  localparam logic [7:0] MASK_PULSE = 8'h3F;
  localparam logic [7:0] MASK_FREQ = 8'h03;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int IND_TICK_US = 62_500;
  localparam int IND_TICK_CYCLES = (CLK_HZ / 1_000_000) * IND_TICK_US;
  localparam int PWM_BASE_HZ = 500;
  localparam int PWM_BASE_CYCLES = CLK_HZ / PWM_BASE_HZ;
  localparam int DUTY_STEPS_LOG2 = 8;
endpackage

// file: test/led_load_model.sv
`timescale 1ns/100ps
// indicator and pin load: counts on cycles and rising edges
module led_load_model (
  // clock and window control
  input wire logic clk_i,
  input wire logic clr_i,
  // ind a, ind b, pwm, gpio
  input wire logic [3:0] lines_i,
  // per-line counts
  output logic [3:0][15:0] on_o,
  output logic [3:0][15:0] rise_o
);
  logic [3:0][15:0] on_q, on_d, rise_q, rise_d;
  logic [3:0] prev_q;
  // next counts, zeroed while the window is closed
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      on_d[i] = clr_i ? 16'h0000 : on_q[i] + {15'h0000, lines_i[i]};
      rise_d[i] = clr_i ? 16'h0000 : rise_q[i] + {15'h0000, lines_i[i] & ~prev_q[i]};
    end
  end
  // register counts and last level
  always_ff @(posedge clk_i) begin
    on_q <= on_d;
    rise_q <= rise_d;
    prev_q <= lines_i;
  end
  assign on_o = on_q;
  assign rise_o = rise_q;
endmodule

// file: test/tb_led_pulse_and_pwm_generator.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_led_pulse_and_pwm_generator import led_pwm_pkg::*;;
  localparam int T = 10;
  localparam int PW = 64;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, clr = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
  logic gpio_is_output_i = 1'b0, gpio_sel_pwm_i = 1'b0, gpio_set_i = 1'b0;
  logic [1:0] ind_o;
  logic pwm_o, gpio_o, gpio_oe_o;
  logic [3:0][15:0] on_c, rise_c;
  int fail_count = 0, total_checks = 0, cyc = 0, len, hi;
  // ch, period code, width code, double
  int tbl [7][4] = '{'{1,2,0,1}, '{1,3,1,1}, '{1,5,2,0}, '{1,4,2,1}, '{0,4,1,1}, '{0,6,3,0},
    '{1,7,3,1}};
  logic [7:0] ofs [4] = '{OFS_PERIOD, OFS_PULSE, OFS_FREQ, OFS_DUTY};
  logic [7:0] msk [4] = '{MASK_PERIOD, MASK_PULSE, MASK_FREQ, 8'hFF};
  logic [7:0] rst [4] = '{RST_PERIOD, RST_PULSE, RST_FREQ, RST_DUTY};
  initial forever #50 clk_i = ~clk_i;
  led_pulse_and_pwm_generator #(.TICK_CYCLES(T), .PWM_CYCLES(PW)) DUT (.clk_i(clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .gpio_is_output_i(gpio_is_output_i),
    .gpio_sel_pwm_i(gpio_sel_pwm_i), .gpio_set_i(gpio_set_i), .ind_o(ind_o), .pwm_o(pwm_o),
    .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o));
  led_load_model load (.clk_i(clk_i), .clr_i(clr), .lines_i({gpio_o, pwm_o, ind_o}),
    .on_o(on_c), .rise_o(rise_c));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // registered read, one edge of latency
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("rdata", e, reg_rdata_o)
  endtask
  // open the load count window for n cycles
  task automatic win(input int n);
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    clr = 1'b1;
  endtask
  // idle both channels, run one setting, count one period
  task automatic ind_case(input int ch, input int p, input int w, input int dbl);
    int pc, wc;
    pc = T << p;
    wc = T << w;
    wr(OFS_PERIOD, 8'h00);
    repeat (1300) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("idle", 2'b00, ind_o)
    wr(OFS_PULSE, 8'((dbl << (ch ? POS_B_DOUBLE : POS_A_DOUBLE)) | (w << (ch ? POS_B_WIDTH : 0))));
    wr(OFS_PERIOD, 8'(p << (ch ? POS_B_PERIOD : POS_A_PERIOD)));
    repeat (2 * pc + T) @(posedge clk_i);
    win(pc);
    `CHK("on", (dbl ? 2 : 1) * wc, on_c[ch])
    `CHK("pulses", dbl ? 2 : 1, rise_c[ch])
    `CHK("other", 0, on_c[1 - ch])
  endtask
  // cycle ceiling against hangs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(20847));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, masked writes, unmapped place
    for (int i = 0; i < 4; i++) rd(ofs[i], rst[i]);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(ofs[i], d);
      rd(ofs[i], d & msk[i]);
    end
    wr(8'h70, 8'hFF);
    rd(8'h70, 8'h00);
    // period codes 1 to 7, single pulse, channel a
    for (int p = 1; p < 8; p++) ind_case(0, p, 0, 0);
    foreach (tbl[i]) ind_case(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
    // every rate, random duty and routing, zero duty last
    for (int i = 0; i < 5; i++) begin
      d = (i == 4) ? 8'h00 : 8'($urandom);
      len = PW << (i % 4);
      hi = (d * len) >> 8;
      @(posedge clk_i);
      {gpio_is_output_i, gpio_sel_pwm_i, gpio_set_i} <= 3'($urandom);
      wr(OFS_FREQ, 8'(i % 4));
      wr(OFS_DUTY, d);
      // old period of up to the slowest rate must end before the new one settles
      repeat ((PW << 3) + len + 4) @(posedge clk_i);
      win(len);
      `CHK("pwm", hi, on_c[2])
      `CHK("pwm_periods", (hi != 0) ? 1 : 0, rise_c[2])
      `CHK("pin", gpio_is_output_i ? (gpio_sel_pwm_i ? hi : gpio_set_i * len) : 0, on_c[3])
      `CHK("pin_oe", gpio_is_output_i, gpio_oe_o)
    end
    complete_run();
  end
endmodule
